// *** include/lcd_cfg.svh ***
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH
// ****************************************************************
// register map: word indices, byte address is four times the index
// ****************************************************************
`define LCD_IDX_LAYOUT 30'h000000E5
`define LCD_IDX_FRAME 30'h000000E6
`define LCD_RST_LAYOUT 8'h00
`define LCD_RST_FRAME 8'h00
// ****************************************************************
// field positions
// ****************************************************************
`define LCD_CS_BIT 7
`define LCD_HB_BIT 6
`define LCD_MUX_HI 5
`define LCD_MUX_LO 4
`define LCD_PM_HI 3
`define LCD_PM_LO 0
`define LCD_PS_HI 6
`define LCD_PS_LO 4
`define LCD_CD_HI 2
`define LCD_CD_LO 0
// ****************************************************************
// bus answers and timing constants
// ****************************************************************
`define LCD_RESP_OKAY 2'h0
`define LCD_RESP_SLVERR 2'h2
`define LCD_MUX_STATIC 2'h0
`define LCD_MUX_THIRD 2'h2
`define LCD_K_THIRD 4'h6
`define LCD_K_OTHER 4'h8
`define LCD_N_BASE_SHIFT 4'h4
`define LCD_N_STEP_SHIFT 4'h5
`define LCD_SEG_BASE_LO 6'h0D
`define LCD_SEG_BASE_HI 6'h1B
`define LCD_SEG_CODE6 6'h18
`define LCD_SEG_CODE7 6'h19
`define LCD_SEG_CODE15 6'h28
`define LCD_SEG_PINS 40
`define LCD_COM_PINS 4
`endif

// *** include/lcd_pkg.sv ***
package lcd_pkg;
  // drive level scheme applied to the glass
  typedef enum logic [1:0]
  {
    DRIVE_STATIC = 2'b00,
    DRIVE_HALF = 2'b01,
    DRIVE_THIRD = 2'b10
  } drive_mode_t;
endpackage

// *** include/lcd_cfg_if.sv ***
`timescale 1ns/1ps
interface lcd_cfg_if;
  logic half_bias_select;
  logic [1:0] common_mux_select;
  logic [3:0] segment_pin_mask;
  logic [2:0] frame_prescale_select;
  logic [2:0] frame_clock_divide;
  logic cfg_wr;
  logic lcd_tick;
  logic ps_tick;
  modport owner (output half_bias_select, common_mux_select, segment_pin_mask,
    frame_prescale_select, frame_clock_divide, cfg_wr, lcd_tick, input ps_tick);
  modport presc (input frame_prescale_select, frame_clock_divide, cfg_wr, lcd_tick,
    output ps_tick);
  modport mapper (input half_bias_select, common_mux_select, segment_pin_mask);
endinterface

// *** src/lcd_prescaler.sv ***
`timescale 1ns/1ps
`include "lcd_cfg.svh"
module lcd_prescaler
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // configuration and ticks
  lcd_cfg_if.presc cfg
);
  logic [11:0] pre_cnt_r;
  logic [2:0] div_cnt_r;
  logic ps_tick_r;
  logic [11:0] pre_last;

  // last count of the tap: N-1
  assign pre_last = (cfg.frame_prescale_select == 3'h0) ?
    12'((13'h1 << `LCD_N_BASE_SHIFT) - 13'h1) :
    12'((13'h1 << (`LCD_N_STEP_SHIFT + 4'(cfg.frame_prescale_select))) - 13'h1);

  // prescaler tap then divider by field plus one; a config write restarts both
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pre_cnt_r <= 12'h000;
      div_cnt_r <= 3'h0;
      ps_tick_r <= 1'b0;
    end
    else if (cfg.cfg_wr)
    begin
      pre_cnt_r <= 12'h000;
      div_cnt_r <= 3'h0;
      ps_tick_r <= 1'b0;
    end
    else
    begin
      ps_tick_r <= 1'b0;
      if (cfg.lcd_tick)
      begin
        if (pre_cnt_r == pre_last)
        begin
          pre_cnt_r <= 12'h000;
          if (div_cnt_r == cfg.frame_clock_divide)
          begin
            div_cnt_r <= 3'h0;
            ps_tick_r <= 1'b1;
          end
          else
          begin
            div_cnt_r <= div_cnt_r + 3'h1;
          end
        end
        else
        begin
          pre_cnt_r <= pre_cnt_r + 12'h001;
        end
      end
    end
  end

  assign cfg.ps_tick = ps_tick_r;
endmodule // lcd_prescaler

// *** src/lcd_pin_mapper.sv ***
`timescale 1ns/1ps
`include "lcd_cfg.svh"
module lcd_pin_mapper
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // configuration
  lcd_cfg_if.mapper cfg,
  // pin ownership and drive scheme
  output logic [`LCD_COM_PINS-1:0] com_drive_o,
  output logic [`LCD_SEG_PINS-1:0] seg_drive_o,
  output lcd_pkg::drive_mode_t drive_mode_o
);
  // segment pin count for a mask code
  function automatic logic [5:0] seg_count(input logic [3:0] code);
    logic [5:0] n;
    n = `LCD_SEG_BASE_LO;
    case (code)
      4'h6: n = `LCD_SEG_CODE6;
      4'h7: n = `LCD_SEG_CODE7;
      4'hF: n = `LCD_SEG_CODE15;
      default:
        if (code < 4'h6)
          n = `LCD_SEG_BASE_LO + {1'b0, code[2:0], 1'b0} ;
        else
          n = `LCD_SEG_BASE_HI + {1'b0, code[2:0], 1'b0};
    endcase
    return n;
  endfunction

  logic [5:0] seg_n;
  assign seg_n = seg_count(cfg.segment_pin_mask);

  // one flop per pin; unused pins go back to port function
  genvar i;
  generate
    for (i = 0; i < `LCD_SEG_PINS; i++)
    begin : g_seg
      always_ff @(posedge clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
          seg_drive_o[i] <= 1'b0;
        else
          seg_drive_o[i] <= (6'(i) < seg_n);
      end
    end
    for (i = 0; i < `LCD_COM_PINS; i++)
    begin : g_com
      always_ff @(posedge clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
          com_drive_o[i] <= 1'b0;
        else
          com_drive_o[i] <= (2'(i) <= cfg.common_mux_select);
      end
    end
  endgenerate

  // static duty ignores the bias bit
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      drive_mode_o <= lcd_pkg::DRIVE_STATIC;
    else if (cfg.common_mux_select == `LCD_MUX_STATIC)
      drive_mode_o <= lcd_pkg::DRIVE_STATIC;
    else if (cfg.half_bias_select)
      drive_mode_o <= lcd_pkg::DRIVE_HALF;
    else
      drive_mode_o <= lcd_pkg::DRIVE_THIRD;
  end
endmodule // lcd_pin_mapper

// *** src/lcd_clock_and_layout_config.sv ***
// Contract
// - source bit picks system or asynchronous clock
// - async clock: oscillator or external input
// - bias bit picks half or third bias
// - mux field picks duty and commons
// - unused commons stay ordinary port pins
// - static duty ignores the bias bit
// - mask code sets segment pin count
// - surplus segment pins stay port pins
// - small variant: mask top bit reads zero
// - prescale code picks divide 16 to 4096
// - divider output forms the prescaled clock
// - frame register bits 7, 3 read zero
// - divide field gives ratio value plus one
// - frame equals clock over K N D
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "lcd_cfg.svh"
module lcd_clock_and_layout_config
#(
  parameter bit LARGE_VARIANT = 1'b1
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // axi4-lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // asynchronous clock sources
  input wire logic timer_osc_clk_i,
  input wire logic ext_clk_i,
  input wire logic external_clock_input_select_i,
  // panel timing and pin ownership
  output logic prescaled_panel_clock_o,
  output logic frame_start_o,
  output logic [`LCD_COM_PINS-1:0] com_drive_o,
  output logic [`LCD_SEG_PINS-1:0] seg_drive_o,
  output lcd_pkg::drive_mode_t drive_mode_o
);
  // ****************************************************************
  // register storage
  // ****************************************************************
  logic clock_source_select_r;
  logic half_bias_select_r;
  logic [1:0] common_mux_select_r;
  logic [3:0] segment_pin_mask_r;
  logic [2:0] frame_prescale_select_r;
  logic [2:0] frame_clock_divide_r;

  // ****************************************************************
  // bus slave state
  // ****************************************************************
  logic aw_held_r;
  logic w_held_r;
  logic [31:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wstrb0_r;
  logic wr_fire;
  logic [1:0] wr_sel;
  logic [1:0] rd_sel;
  logic [7:0] layout_rd;
  logic [7:0] frame_rd;

  // one-hot decode of a byte address: bit 0 layout, bit 1 frame rate
  function automatic logic [1:0] reg_sel(input logic [31:0] addr);
    logic [1:0] s;
    s = 2'h0;
    if (addr[1:0] == 2'h0)
    begin
      s[0] = (addr[31:2] == `LCD_IDX_LAYOUT);
      s[1] = (addr[31:2] == `LCD_IDX_FRAME);
    end
    return s;
  endfunction

  // address and data may come in either order; hold until both are here
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_sel = reg_sel(awaddr_r);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      aw_held_r <= 1'b0;
      awaddr_r <= 32'h00000000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end
    else if (wr_fire)
    begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      w_held_r <= 1'b0;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata[7:0];
      wstrb0_r <= s_axi_wstrb[0];
    end
    else if (wr_fire)
    begin
      w_held_r <= 1'b0;
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LCD_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_sel != 2'h0) ? `LCD_RESP_OKAY : `LCD_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // layout register; only byte lane 0 carries data
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      clock_source_select_r <= 1'(`LCD_RST_LAYOUT >> `LCD_CS_BIT);
      half_bias_select_r <= 1'b0;
      common_mux_select_r <= 2'h0;
      segment_pin_mask_r <= 4'h0;
    end
    else if (wr_fire && wr_sel[0] && wstrb0_r)
    begin
      clock_source_select_r <= wdata_r[`LCD_CS_BIT];
      half_bias_select_r <= wdata_r[`LCD_HB_BIT];
      common_mux_select_r <= wdata_r[`LCD_MUX_HI:`LCD_MUX_LO];
      // small variant has no top mask bit
      segment_pin_mask_r <= {wdata_r[`LCD_PM_HI] & LARGE_VARIANT,
        wdata_r[`LCD_PM_HI-1:`LCD_PM_LO]};
    end
  end

  // frame rate register; reserved bits are simply not stored
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      frame_prescale_select_r <= 3'h0;
      frame_clock_divide_r <= 3'h0;
    end
    else if (wr_fire && wr_sel[1] && wstrb0_r)
    begin
      frame_prescale_select_r <= wdata_r[`LCD_PS_HI:`LCD_PS_LO];
      frame_clock_divide_r <= wdata_r[`LCD_CD_HI:`LCD_CD_LO];
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  assign layout_rd = {clock_source_select_r, half_bias_select_r, common_mux_select_r,
    segment_pin_mask_r};
  assign frame_rd = {1'b0, frame_prescale_select_r, 1'b0, frame_clock_divide_r};
  assign rd_sel = reg_sel(s_axi_araddr);
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LCD_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_sel[0] ? {24'h000000, layout_rd} :
        rd_sel[1] ? {24'h000000, frame_rd} : 32'h00000000;
      s_axi_rresp <= (rd_sel != 2'h0) ? `LCD_RESP_OKAY : `LCD_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // panel clock source
  // ****************************************************************
  logic async_src;
  logic async_prev_r;
  logic lcd_tick_r;

  // pins are synchronous; one flop finds the rising edge of the async source
  assign async_src = external_clock_input_select_i ? ext_clk_i : timer_osc_clk_i;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      async_prev_r <= 1'b0;
      lcd_tick_r <= 1'b0;
    end
    else
    begin
      async_prev_r <= async_src;
      lcd_tick_r <= clock_source_select_r ? (async_src && !async_prev_r) : 1'b1;
    end
  end

  // ****************************************************************
  // submodules
  // ****************************************************************
  lcd_cfg_if cfg_bus ();
  assign cfg_bus.half_bias_select = half_bias_select_r;
  assign cfg_bus.common_mux_select = common_mux_select_r;
  assign cfg_bus.segment_pin_mask = segment_pin_mask_r;
  assign cfg_bus.frame_prescale_select = frame_prescale_select_r;
  assign cfg_bus.frame_clock_divide = frame_clock_divide_r;
  // any config write restarts the timing chain so no stale phase survives
  assign cfg_bus.cfg_wr = wr_fire && (wr_sel != 2'h0);
  assign cfg_bus.lcd_tick = lcd_tick_r;

  lcd_prescaler u_presc
  (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .cfg(cfg_bus.presc)
  );

  lcd_pin_mapper u_map
  (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .cfg(cfg_bus.mapper),
    .com_drive_o(com_drive_o),
    .seg_drive_o(seg_drive_o),
    .drive_mode_o(drive_mode_o)
  );

  // ****************************************************************
  // frame sequencing
  // ****************************************************************
  logic [3:0] frame_cnt_r;
  logic [3:0] k_last;

  // third duty uses six phases per frame, the others eight
  assign k_last = ((common_mux_select_r == `LCD_MUX_THIRD) ? `LCD_K_THIRD : `LCD_K_OTHER)
    - 4'h1;
  assign prescaled_panel_clock_o = cfg_bus.ps_tick;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      frame_cnt_r <= 4'h0;
      frame_start_o <= 1'b0;
    end
    else if (cfg_bus.cfg_wr)
    begin
      frame_cnt_r <= 4'h0;
      frame_start_o <= 1'b0;
    end
    else
    begin
      frame_start_o <= 1'b0;
      if (cfg_bus.ps_tick)
      begin
        if (frame_cnt_r >= k_last)
        begin
          frame_cnt_r <= 4'h0;
          frame_start_o <= 1'b1;
        end
        else
        begin
          frame_cnt_r <= frame_cnt_r + 4'h1;
        end
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [15:0] lcd_span_r;
  logic [3:0] ps_span_r;
  logic [15:0] nd_exp;

  // expected lcd ticks per prescaled tick: N times D
  assign nd_exp = (frame_prescale_select_r == 3'h0) ?
    16'((17'h1 << `LCD_N_BASE_SHIFT) * (17'(frame_clock_divide_r) + 17'h1)) :
    16'((17'h1 << (`LCD_N_STEP_SHIFT + 4'(frame_prescale_select_r)))
      * (17'(frame_clock_divide_r) + 17'h1));

  // helper counts of ticks since the last output tick
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      lcd_span_r <= 16'h0000;
      ps_span_r <= 4'h0;
    end
    else if (cfg_bus.cfg_wr)
    begin
      lcd_span_r <= 16'h0000;
      ps_span_r <= 4'h0;
    end
    else
    begin
      lcd_span_r <= cfg_bus.ps_tick ? 16'(lcd_tick_r) : lcd_span_r + 16'(lcd_tick_r);
      ps_span_r <= frame_start_o ? 4'(cfg_bus.ps_tick) : ps_span_r + 4'(cfg_bus.ps_tick);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_async_edge;
    clock_source_select_r && async_src && !async_prev_r;
  endsequence

  sequence s_written;
    wr_fire && wr_sel[1] && wstrb0_r;
  endsequence

  AST_SRC_SYS: assert property (!clock_source_select_r |=> lcd_tick_r)
    else $error("system clock source gives no tick");
  AST_SRC_ASYNC: assert property (s_async_edge |=> lcd_tick_r)
    else $error("async edge gives no tick");
  AST_SRC_QUIET: assert property (
    clock_source_select_r && !(async_src && !async_prev_r) |=> !lcd_tick_r)
    else $error("tick without async edge");
  AST_BIAS: assert property (
    (common_mux_select_r != `LCD_MUX_STATIC) && $stable(common_mux_select_r)
    ##0 half_bias_select_r |=> drive_mode_o == lcd_pkg::DRIVE_HALF)
    else $error("half bias not applied");
  AST_STATIC: assert property ((common_mux_select_r == `LCD_MUX_STATIC) |=>
    drive_mode_o == lcd_pkg::DRIVE_STATIC)
    else $error("static duty not static drive");
  AST_COM: assert property ((common_mux_select_r == 2'h1) |=> com_drive_o == 4'h3)
    else $error("wrong commons for half duty");
  AST_SEG_MIN: assert property ((segment_pin_mask_r == 4'h0) |=> seg_drive_o ==
    40'h0000001FFF)
    else $error("wrong segment count for code 0");
  AST_SEG_SEVEN: assert property ((segment_pin_mask_r == 4'h7) |=> seg_drive_o ==
    40'h0001FFFFFF)
    else $error("wrong segment count for code 7");
  AST_VARIANT: assert property (!LARGE_VARIANT |-> !segment_pin_mask_r[3])
    else $error("top mask bit set on small variant");
  AST_RSVD: assert property (s_written |=> frame_rd[7] == 1'b0 && frame_rd[3] == 1'b0
    && frame_clock_divide_r == $past(wdata_r[2:0]))
    else $error("frame register reserved bit or field wrong");
  AST_DIV: assert property (cfg_bus.ps_tick |-> lcd_span_r == nd_exp)
    else $error("prescaled tick spacing not N times D");
  AST_FRAME: assert property (frame_start_o |-> ps_span_r == k_last + 4'h1)
    else $error("frame length not K prescaled ticks");
endmodule // lcd_clock_and_layout_config

// *** dv/lcd_glass_model.sv ***
`timescale 1ns/1ps
// ****************************************
// passive glass: counts frames, keeps commons seen
// ****************************************
module lcd_glass_model
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // drive from the controller
  input wire logic frame_start_i,
  input wire logic [3:0] com_drive_i,
  input wire logic [39:0] seg_drive_i,
  input wire lcd_pkg::drive_mode_t drive_mode_i,
  // what the glass saw at the last frame start
  output int frames_o,
  output int commons_o,
  output int segments_o,
  output lcd_pkg::drive_mode_t mode_o
);
  // glass only latches at frame start, it never loads the pins back
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      frames_o <= 0;
      commons_o <= 0;
      segments_o <= 0;
      mode_o <= lcd_pkg::DRIVE_STATIC;
    end
    else if (frame_start_i)
    begin
      frames_o <= frames_o + 1;
      commons_o <= $countones(com_drive_i);
      segments_o <= $countones(seg_drive_i);
      mode_o <= drive_mode_i;
    end
  end
endmodule // lcd_glass_model

// *** dv/lcd_clock_and_layout_config_test.sv ***
`timescale 1ns/1ps
`include "lcd_cfg.svh"
module lcd_clock_and_layout_config_test;
  // ****************************************
  // signals
  // ****************************************
  logic clk_i = 0, resetn_i = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, rvalid_s;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rdata_s, rdata_s_q;
  logic osc = 0, ext = 0, ext_sel = 0;
  logic [1:0] oc = 0;
  logic [1:0] ec = 0;
  logic pclk, fstart;
  logic [3:0] com;
  logic [39:0] seg, seg_s;
  lcd_pkg::drive_mode_t mode;
  int frames, commons, segs, fails = 0, checked = 0;
  lcd_pkg::drive_mode_t gmode;
  localparam logic [31:0] A_LAY = {`LCD_IDX_LAYOUT, 2'b00};
  localparam logic [31:0] A_FRM = {`LCD_IDX_FRAME, 2'b00};
  always #5 clk_i = ~clk_i;
  // async sources: period 8 and 6 system clocks
  always @(posedge clk_i)
  begin
    oc <= oc + 2'h1;
    ec <= (ec == 2'h2) ? 2'h0 : ec + 2'h1;
    if (oc == 2'h3) osc <= ~osc;
    if (ec == 2'h2) ext <= ~ext;
  end
  // ****************************************
  // design, small variant and glass
  // ****************************************
  lcd_clock_and_layout_config u_lcd_clock_and_layout_config (.clk_i(clk_i), .resetn_i(resetn_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_osc_clk_i(osc), .ext_clk_i(ext), .external_clock_input_select_i(ext_sel),
    .prescaled_panel_clock_o(pclk), .frame_start_o(fstart), .com_drive_o(com),
    .seg_drive_o(seg), .drive_mode_o(mode));
  // small part shares the bus inputs; only its read data and segments are watched
  lcd_clock_and_layout_config #(.LARGE_VARIANT(1'b0)) u_lcd_clock_and_layout_config_small (
    .clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(rdata_s),
    .s_axi_rresp(), .s_axi_rvalid(rvalid_s), .s_axi_rready(rready), .timer_osc_clk_i(osc),
    .ext_clk_i(ext), .external_clock_input_select_i(ext_sel), .prescaled_panel_clock_o(),
    .frame_start_o(), .com_drive_o(), .seg_drive_o(seg_s), .drive_mode_o());
  lcd_glass_model u_lcd_glass_model (.clk_i(clk_i), .resetn_i(resetn_i),
    .frame_start_i(fstart), .com_drive_i(com), .seg_drive_i(seg), .drive_mode_i(mode),
    .frames_o(frames), .commons_o(commons), .segments_o(segs), .mode_o(gmode));
  // ****************************************
  // tasks
  // ****************************************
  task automatic print_verdict();
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang();
    fails++;
    print_verdict();
  endtask
  // handshakes judged at the falling edge, acted on right after the rising edge
  task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
    bit ah, wh, bh;
    @(posedge clk_i);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (int i = 0; i < 100; i++)
    begin
      @(negedge clk_i);
      ah = awvalid && awready; wh = wvalid && wready; bh = bvalid; r = bresp;
      @(posedge clk_i);
      if (ah) awvalid <= 0;
      if (wh) wvalid <= 0;
      if (bh)
      begin
        bready <= 0;
        return;
      end
    end
    hang();
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ah, rh;
    @(posedge clk_i);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (int i = 0; i < 100; i++)
    begin
      @(negedge clk_i);
      ah = arvalid && arready; rh = rvalid; d = rdata; r = rresp; rdata_s_q = rdata_s;
      @(posedge clk_i);
      if (ah) arvalid <= 0;
      if (rh)
      begin
        rready <= 0;
        return;
      end
    end
    hang();
  endtask
  // cycles between two pulses of the panel clock (f=0) or frame start (f=1)
  task automatic period(input bit f, output int n);
    int i;
    for (i = 0; i < 20000; i++)
    begin
      @(negedge clk_i);
      if (f ? fstart : pclk) break;
    end
    if (i == 20000) hang();
    for (n = 1; n < 20000; n++)
    begin
      @(negedge clk_i);
      if (f ? fstart : pclk) break;
    end
  endtask
  task automatic timing(input logic [7:0] lay, input logic [7:0] frr, input bit f,
    output int n);
    logic [1:0] r;
    wr(A_LAY, lay, r);
    wr(A_FRM, frr, r);
    period(f, n);
  endtask
  function automatic int segn(input int c);
    if (c < 6) return 13 + 2 * c;
    if (c < 8) return c + 18;
    if (c < 15) return 27 + 2 * (c - 8);
    return 40;
  endfunction
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    int f0;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1;
    rd(A_LAY, d, r); chk("layout reset", 40'h0, d);
    rd(A_FRM, d, r); chk("frame reset", 40'h0, d);
    chk("seg after reset", 40'h1FFF, seg);
    for (int m = 0; m < 4; m++)
      for (int b = 0; b < 2; b++)
      begin
        wr(A_LAY, {1'b0, b[0], m[1:0], 4'h0}, r);
        chk("wr resp", `LCD_RESP_OKAY, r);
        repeat (2) @(posedge clk_i);
        rd(A_LAY, d, r); chk("layout rb", {b[0], m[1:0], 4'h0}, d);
        chk("commons", (40'h1 << (m + 1)) - 40'h1, com);
        chk("mode", (m == 0) ? lcd_pkg::DRIVE_STATIC : b ? lcd_pkg::DRIVE_HALF
          : lcd_pkg::DRIVE_THIRD, mode);
      end
    for (int c = 0; c < 16; c++)
    begin
      wr(A_LAY, {4'h0, c[3:0]}, r);
      repeat (2) @(posedge clk_i);
      chk("segments", (40'h1 << segn(c)) - 40'h1, seg);
      rd(A_LAY, d, r); chk("small mask", {5'h0, c[2:0]}, rdata_s_q);
      chk("small segs", (40'h1 << segn(c % 8)) - 40'h1, seg_s);
    end
    wr(32'h400, 8'hFF, r); chk("unmapped wr", `LCD_RESP_SLVERR, r);
    rd(32'h400, d, r); chk("unmapped rd", {`LCD_RESP_SLVERR, 32'h0}, {r, d});
    wr(A_FRM, 8'hFF, r);
    rd(A_FRM, d, r); chk("frame reserved", 40'h77, d);
    for (int p = 0; p < 8; p++)
    begin
      timing(8'h00, {1'b0, p[2:0], 4'h0}, 0, n);
      chk("prescale", (p == 0) ? 16 : (1 << (p + 5)), n);
    end
    timing(8'h00, 8'h02, 0, n); chk("divide", 48, n);
    timing(8'h20, 8'h02, 1, n); chk("frame third", 288, n);
    timing(8'h30, 8'h07, 1, n); chk("frame quarter", 1024, n);
    f0 = frames;
    repeat (1024) @(negedge clk_i);
    chk("glass frames", f0 + 1, frames);
    chk("glass commons", 4, commons);
    chk("glass segs", 13, segs);
    chk("glass mode", lcd_pkg::DRIVE_THIRD, gmode);
    timing(8'h80, 8'h00, 0, n); chk("osc clock", 128, n);
    ext_sel <= 1;
    timing(8'h80, 8'h00, 0, n); chk("ext clock", 96, n);
    print_verdict();
  end
endmodule // lcd_clock_and_layout_config_test
